// [test/sdp_ctl_model.sv]
// Behavioural debug command controller facing the serial debug port
`timescale 1ns/1ns
module sdp_ctl_model (
  output logic      debug_serial_clock,  // Serial clock, low between frames
  output logic      dsi,   // Serial data towards the port
  output logic      req_n, // Debug request, low active
  input  wire logic debug_serial_out    // Serial data and acknowledge
);
  initial begin
    debug_serial_clock = 1'b0;
    dsi = 1'b0;
    req_n = 1'b1;
  end
  // ==========================================================
  // One bit per 400 ns; data moves mid-high so it is steady well past the fall.
  // Output is taken before the rise, since that rise moves the port to the next bit
  task automatic bit_xfer(input logic w, output logic r);
    r = debug_serial_out;
    debug_serial_clock = 1'b1;
    #100 dsi = w;
    #100 debug_serial_clock = 1'b0;
    #200;
  endtask : bit_xfer
  // Bounded wait for a low pulse; the request is dropped on_chip_emulation_port it shows
  task automatic wait_ack(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) #50 ok = (debug_serial_out === 1'b0);
    req_n = 1'b1;
    #300;
  endtask : wait_ack
endmodule : sdp_ctl_model

// [test/sdp_top_properties.sv]
// Checker of the serial debug port pin turn-around and handshake timing
`timescale 1ns/1ns
module sdp_props (
  input wire logic       REF_CLK,                     // Clock
  input wire logic       RSTN,                        // Reset, low active
  input wire logic       DEBUG_DATA_IN_OR_STATUS0_O,  // Data pin value
  input wire logic       DEBUG_DATA_IN_OR_STATUS0_OE, // Data pin enable
  input wire logic       DEBUG_CLOCK_OR_STATUS1_O,    // Clock pin value
  input wire logic       DEBUG_CLOCK_OR_STATUS1_OE,   // Clock pin enable
  input wire logic       DEBUG_SERIAL_OUT,            // Serial out
  input wire logic [1:0] CORE_STATE,                  // Core state
  input wire logic       CORE_HALT,                   // Halt
  input wire logic       ACC_WR,                      // Write strobe
  input wire logic       ACC_RD                       // Read strobe
);
  // Short aliases of the pin signals
  wire d_o  = DEBUG_DATA_IN_OR_STATUS0_O;
  wire d_oe = DEBUG_DATA_IN_OR_STATUS0_OE;
  wire c_o  = DEBUG_CLOCK_OR_STATUS1_O;
  wire c_oe = DEBUG_CLOCK_OR_STATUS1_OE;
  wire so   = DEBUG_SERIAL_OUT;
  // ==========================================================
  // Properties
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  a_reset_pins_low: assert property (disable iff (1'b0) !RSTN |=> d_oe && c_oe && !d_o && !c_o)
    else $error("status pins not driven low in reset");
  a_status_bit0: assert property ($past(RSTN) && d_oe && $stable(CORE_STATE) |-> d_o == CORE_STATE[0])
    else $error("data pin does not carry status bit 0");
  a_status_bit1: assert property ($past(RSTN) && c_oe && $stable(CORE_STATE) |-> c_o == CORE_STATE[1])
    else $error("clock pin does not carry status bit 1");
  a_data_release: assert property ($fell(d_oe) |-> so [*2])
    else $error("acknowledge during data pin turn-around");
  a_entry_ack: assert property ($fell(c_oe) |-> ##[1:8] !so)
    else $error("no acknowledge after debug entry");
  a_clk_release: assert property ($rose(c_oe) |-> !$past(c_oe, 2))
    else $error("clock pin driven without high impedance gap");
  a_write_strobe: assert property (ACC_WR |-> CORE_HALT && !d_oe ##1 !ACC_WR ##[0:8] !so)
    else $error("write strobe or its acknowledge wrong");
  a_read_strobe: assert property (ACC_RD |-> CORE_HALT && !ACC_WR ##1 !ACC_RD)
    else $error("read strobe outside debug or too long");
  a_idle_high: assert property (d_oe |-> so)
    else $error("serial out low outside debug");
  // Main scenarios
  c_write: cover property (ACC_WR);
  c_read: cover property (ACC_RD);
  c_exit: cover property ($rose(c_oe));
endmodule : sdp_props
bind sdp_top sdp_props u_props (.*);

// [test/tb_top.sv]
// Self-checking bench of the serial debug port against the controller model
`timescale 1ns/1ns
module tb_top;
  import sdp_pkg::*;
  // ==========================================================
  // Design pins, named as the ports so the instance binds them by name
  logic REF_CLK = 1'b0, RSTN = 1'b0, INSTR_DONE = 1'b0;
  logic [1:0] CORE_STATE = 2'h0;
  logic [DATA_W-1:0] ACC_RDATA = 24'h3c5a96;
  logic DEBUG_DATA_IN_OR_STATUS0_O, DEBUG_DATA_IN_OR_STATUS0_OE, DEBUG_CLOCK_OR_STATUS1_O;
  logic DEBUG_CLOCK_OR_STATUS1_OE, DEBUG_SERIAL_OUT, CORE_HALT, ACC_WR, ACC_RD;
  logic [CMD_ADDR_W-1:0] ACC_ADDR, wr_addr, rd_addr;
  logic [DATA_W-1:0] ACC_WDATA, wr_data, got;
  wire DEBUG_REQUEST_N, dsi, debug_serial_clock;
  // Released pins fall back to what the controller drives
  wire DEBUG_DATA_IN_OR_STATUS0_I = DEBUG_DATA_IN_OR_STATUS0_OE ? DEBUG_DATA_IN_OR_STATUS0_O : dsi;
  wire DEBUG_CLOCK_OR_STATUS1_I = DEBUG_CLOCK_OR_STATUS1_OE ? DEBUG_CLOCK_OR_STATUS1_O : debug_serial_clock;
  wire [3:0] pins = {DEBUG_CLOCK_OR_STATUS1_OE, DEBUG_DATA_IN_OR_STATUS0_OE,
                     DEBUG_CLOCK_OR_STATUS1_O, DEBUG_DATA_IN_OR_STATUS0_O};
  int errors = 0, samples_checked = 0, cycles = 0, wr_cnt = 0;
  logic b;
  bit ok;
  // Rows: {enables, clock pin, data pin, core state}
  logic [5:0] rows [4] = '{6'h30, 6'h35, 6'h3a, 6'h3f};
  sdp_top dut (.*);
  sdp_ctl_model ctl (.debug_serial_clock(debug_serial_clock), .dsi(dsi), .req_n(DEBUG_REQUEST_N), .debug_serial_out(DEBUG_SERIAL_OUT));
  always #25 REF_CLK = ~REF_CLK;
  // Write strobe capture away from the launching edge, and hang guard
  always @(negedge REF_CLK) begin
    cycles++;
    if (ACC_WR === 1'b1) begin
      wr_cnt++;
      wr_addr = ACC_ADDR;
      wr_data = ACC_WDATA;
    end
    if (ACC_RD === 1'b1) rd_addr = ACC_ADDR;
    if (cycles == 4000) begin
      errors++;
      complete_run();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic send_cmd(input logic [7:0] c);
    for (int i = 7; i >= 0; i--) ctl.bit_xfer(c[i], b);
    ctl.wait_ack(ok);
    check("command ack", 1'b1, ok);
  endtask : send_cmd
  task automatic data24(input logic [23:0] w);
    got = '0;
    for (int i = 23; i >= 0; i--) begin
      ctl.bit_xfer(w[i], b);
      got = {got[22:0], b};
    end
    ctl.wait_ack(ok);
  endtask : data24
  task automatic complete_run;
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Sequence
  initial begin
    repeat (3) @(negedge REF_CLK);
    check("reset pins", 6'h32, {pins, DEBUG_SERIAL_OUT, CORE_HALT});
    RSTN = 1'b1;
    foreach (rows[r]) begin
      CORE_STATE = rows[r][1:0];
      repeat (3) @(negedge REF_CLK);
      check("status pins", rows[r][5:2], pins);
    end
    // Serial traffic outside debug must be ignored
    data24(24'hffffff);
    check("idle writes", 0, wr_cnt);
    // Request while the instruction is still running: pins stay put
    ctl.req_n = 1'b0;
    repeat (12) @(negedge REF_CLK);
    check("entry before done", 2'h3, {DEBUG_DATA_IN_OR_STATUS0_OE, DEBUG_SERIAL_OUT});
    INSTR_DONE = 1'b1;
    ctl.wait_ack(ok);
    check("entry ack", 1'b1, ok);
    check("pins released", 3'h1, {pins[3:2], CORE_HALT});
    send_cmd(8'h05);
    data24(24'ha5c3e1);
    check("write ack", 1'b1, ok);
    check("write addr", 5'h05, wr_addr);
    check("write data", 24'ha5c3e1, wr_data);
    check("write count", 1, wr_cnt);
    // Read with exit: bits leave most significant first
    send_cmd(8'hc9);
    data24(24'h000000);
    check("read data", 24'h3c5a96, got);
    check("read addr", 5'h09, rd_addr);
    repeat (20) @(negedge REF_CLK);
    check("status restored", 3'h6, {pins[3:2], CORE_HALT});
    complete_run();
  end
endmodule : tb_top

// [verilog/sdp_pkg.sv]
// Package of constants and carrier types for the serial debug port
package sdp_pkg;
  // ==========================================================
  // Word layout
  localparam int          CMD_W       = 8;
  localparam int          DATA_W      = 24;
  localparam int          CMD_RW_BIT  = 7;           // 1 = read
  localparam int          CMD_GO_BIT  = 6;           // 1 = leave debug after command
  localparam int          CMD_ADDR_W  = 5;
  localparam int          REG_NUM     = 32;
  localparam int          BITCNT_W    = 5;
  // ==========================================================
  // Timing in ns, and counts in processor clock cycles
  localparam int          CLK_NS      = 50;
  localparam int          ACK_NS      = 100;
  localparam logic [3:0]  ACK_CYC     = 4'((ACK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  HIZ_CYC     = 4'h2;        // Release time before turning a pin
  // ==========================================================
  // Status encoding on the two status pins
  localparam logic [1:0]  ST_NORMAL   = 2'h0;
  localparam logic [1:0]  ST_STOPWAIT = 2'h1;
  localparam logic [1:0]  ST_EXCEPT   = 2'h2;
  localparam logic [1:0]  ST_DEBUG    = 2'h3;
  localparam logic [1:0]  ST_RESET    = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 24'h000000;

  typedef enum {
    SDP_RUN, SDP_FINISH, SDP_REL, SDP_ACK0, SDP_CMD, SDP_ACK1, SDP_DATA, SDP_ACK2, SDP_EXIT
  } sdp_state_e;

  // Processor side of the debug access
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [CMD_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata;
  } sdp_acc_s;

  // Output value and enable of a two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } sdp_pin_s;
endpackage : sdp_pkg

// [verilog/sdp_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module sdp_sync (
  input  wire logic clk,                  // Processor clock
  input  wire logic rst_n,                // Synchronous reset
  input  wire logic rst_val,              // Level held during reset
  input  wire logic din,                  // Asynchronous input
  output logic      dout                  // Filtered level
);
  logic s1;
  logic s2;
  logic s3;

  // ==========================================================
  // Only s2 reads s1; a change counts on_chip_emulation_port s2 and s3 agree
  always_ff @(posedge clk) begin
    s1 <= din;
    s2 <= s1;
    s3 <= s2;
    if (!rst_n) begin
      dout <= rst_val;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule : sdp_sync

// [verilog/sdp_top.sv]
// Serial debug port with shared status pins
`timescale 1ns/1ns
module sdp_top
  import sdp_pkg::*;
(
  input  wire logic                         REF_CLK,      // Processor clock, 20 MHz
  input  wire logic                         RSTN,         // Synchronous reset, low active
  input  wire logic                         DEBUG_REQUEST_N, // Debug request from controller
  input  wire logic                         DEBUG_DATA_IN_OR_STATUS0_I, // Data pin level
  output logic                              DEBUG_DATA_IN_OR_STATUS0_O, // Data pin drive value
  output logic                              DEBUG_DATA_IN_OR_STATUS0_OE, // Data pin drive enable
  input  wire logic                         DEBUG_CLOCK_OR_STATUS1_I, // Clock pin level
  output logic                              DEBUG_CLOCK_OR_STATUS1_O, // Clock pin drive value
  output logic                              DEBUG_CLOCK_OR_STATUS1_OE, // Clock pin drive enable
  output logic                              DEBUG_SERIAL_OUT, // Serial data and acknowledge
  input  wire logic [1:0]                   CORE_STATE,   // Core state, sdp_pkg encoding
  input  wire logic                         INSTR_DONE,   // Current instruction finished
  output logic                              CORE_HALT,    // Core held in debug mode
  output logic                              ACC_WR,       // Debug register write pulse
  output logic                              ACC_RD,       // Debug register read pulse
  output logic [CMD_ADDR_W-1:0]             ACC_ADDR,     // Debug register number
  output logic [DATA_W-1:0]                 ACC_WDATA,    // Debug write data
  input  wire logic [DATA_W-1:0]            ACC_RDATA     // Debug read data, taken as the read acknowledge after ACC_RD ends
);
  import sdp_pkg::*;

  sdp_state_e        state;
  sdp_state_e        next_state;
  logic              dclk;
  logic              dclk_q;
  logic              din;
  logic              req_n;
  logic [DATA_W-1:0] shreg;
  logic [BITCNT_W-1:0] bitcnt;
  logic [3:0]        tmr;
  logic              is_read;
  logic              go_flag;
  logic [CMD_ADDR_W-1:0] addr;
  sdp_acc_s          acc;

  // ==========================================================
  // Input synchronisers; the clock pin is sampled like data
  sdp_sync u_clk (.clk(REF_CLK), .rst_n(RSTN), .rst_val(1'b0),
                  .din(DEBUG_CLOCK_OR_STATUS1_I), .dout(dclk));
  sdp_sync u_din (.clk(REF_CLK), .rst_n(RSTN), .rst_val(1'b0),
                  .din(DEBUG_DATA_IN_OR_STATUS0_I), .dout(din));
  sdp_sync u_req (.clk(REF_CLK), .rst_n(RSTN), .rst_val(1'b1),
                  .din(DEBUG_REQUEST_N), .dout(req_n));

  // ==========================================================
  // Edge detection; edges only matter on_chip_emulation_port pins are inputs
  wire  in_debug  = (state == SDP_CMD) || (state == SDP_DATA) || (state == SDP_ACK0)
                    || (state == SDP_ACK1) || (state == SDP_ACK2);
  wire  fall      = dclk_q & ~dclk & in_debug;
  wire  rise      = ~dclk_q & dclk & in_debug;
  wire  last_bit  = (bitcnt == 5'h00);
  wire  tmr_done  = (tmr == 4'h0);
  // Bit count of the word now shifting, less one
  wire  [BITCNT_W-1:0] cmd_len  = BITCNT_W'(CMD_W - 1);
  wire  [BITCNT_W-1:0] data_len = BITCNT_W'(DATA_W - 1);
  // Status value shown when the pins are outputs; follows the same decode as the enables
  // so a pin never shows the debug code in the cycle it turns back to status
  wire  [1:0] status = ((next_state == SDP_RUN) || (next_state == SDP_FINISH)) ? CORE_STATE : ST_DEBUG;

  // ==========================================================
  // Next-state decode
  always_comb begin
    next_state = state;
    case (state)
      SDP_RUN:    if (!req_n) next_state = SDP_FINISH;
      SDP_FINISH: if (INSTR_DONE) next_state = SDP_REL;
      SDP_REL:    if (tmr_done) next_state = SDP_ACK0;
      SDP_ACK0:   if (tmr_done && req_n) next_state = SDP_CMD;
      SDP_CMD:    if (fall && last_bit) next_state = SDP_ACK1;
      SDP_ACK1:   if (tmr_done) next_state = SDP_DATA;
      SDP_DATA:   if ((is_read ? rise : fall) && last_bit) next_state = SDP_ACK2;
      SDP_ACK2:   if (tmr_done) next_state = go_flag ? SDP_EXIT : SDP_CMD;
      SDP_EXIT:   if (tmr_done) next_state = SDP_RUN;
      default:    next_state = SDP_RUN;
    endcase
    // Request while in debug resets the serial controller
    if (in_debug && !req_n && state != SDP_ACK0) next_state = SDP_ACK0;
  end

  // ==========================================================
  // State, timers and edge history
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state  <= SDP_RUN;
      dclk_q <= 1'b0;
      tmr    <= 4'h0;
    end else begin
      state  <= next_state;
      dclk_q <= dclk;
      if (next_state != state) begin
        tmr <= (next_state == SDP_REL || next_state == SDP_EXIT) ? HIZ_CYC : ACK_CYC;
      end else if (!tmr_done) begin
        tmr <= tmr - 4'h1;
      end
    end
  end

  // ==========================================================
  // Shift register: input MSB first on fall, output MSB on rise
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      shreg   <= DATA_RST;
      bitcnt  <= 5'h00;
      is_read <= 1'b0;
      go_flag <= 1'b0;
      addr    <= 5'h00;
    end else if (next_state == SDP_CMD && state != SDP_CMD) begin
      bitcnt  <= cmd_len;
    end else if (state == SDP_CMD && fall) begin
      shreg   <= {shreg[DATA_W-2:0], din};
      bitcnt  <= bitcnt - 5'h01;
      if (last_bit) begin
        is_read <= shreg[CMD_RW_BIT-1];
        go_flag <= shreg[CMD_GO_BIT-1];
        addr    <= {shreg[CMD_ADDR_W-2:0], din};
      end
    end else if (state == SDP_ACK1 && tmr_done) begin
      bitcnt  <= data_len;
      if (is_read) shreg <= ACC_RDATA;
    end else if (state == SDP_DATA && !is_read && fall) begin
      shreg   <= {shreg[DATA_W-2:0], din};
      bitcnt  <= bitcnt - 5'h01;
    end else if (state == SDP_DATA && is_read && rise) begin
      shreg   <= {shreg[DATA_W-2:0], 1'b0};
      bitcnt  <= bitcnt - 5'h01;
    end
  end

  // ==========================================================
  // Core access strobes; read strobed as its acknowledge starts, data taken when it ends
  always_comb begin
    acc       = '0;
    acc.addr  = addr;
    acc.wdata = shreg;
    acc.rd    = (state == SDP_CMD) && fall && last_bit && shreg[CMD_RW_BIT-1];
    acc.wr    = (state == SDP_DATA) && !is_read && fall && last_bit;
  end

  // ==========================================================
  // Registered pin drivers
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      DEBUG_DATA_IN_OR_STATUS0_O  <= 1'b0;
      DEBUG_DATA_IN_OR_STATUS0_OE <= 1'b1;
      DEBUG_CLOCK_OR_STATUS1_O    <= 1'b0;
      DEBUG_CLOCK_OR_STATUS1_OE   <= 1'b1;
      DEBUG_SERIAL_OUT            <= 1'b1;
      CORE_HALT                   <= 1'b0;
      ACC_WR                      <= 1'b0;
      ACC_RD                      <= 1'b0;
      ACC_ADDR                    <= 5'h00;
      ACC_WDATA                   <= DATA_RST;
    end else begin
      // Pins drive status only in run and finish; released otherwise
      DEBUG_DATA_IN_OR_STATUS0_O  <= status[0];
      DEBUG_DATA_IN_OR_STATUS0_OE <= (next_state == SDP_RUN) || (next_state == SDP_FINISH);
      DEBUG_CLOCK_OR_STATUS1_O    <= status[1];
      DEBUG_CLOCK_OR_STATUS1_OE   <= (next_state == SDP_RUN) || (next_state == SDP_FINISH);
      // Low pulse in acknowledge states, MSB of the shifter while reading data, else high
      if (next_state == SDP_ACK0 || next_state == SDP_ACK1 || next_state == SDP_ACK2) begin
        DEBUG_SERIAL_OUT <= 1'b0;
      end else if (state == SDP_DATA && is_read) begin
        DEBUG_SERIAL_OUT <= shreg[DATA_W-1];
      end else begin
        DEBUG_SERIAL_OUT <= 1'b1;
      end
      CORE_HALT <= (next_state != SDP_RUN) && (next_state != SDP_FINISH);
      ACC_WR    <= acc.wr;
      ACC_RD    <= acc.rd;
      ACC_ADDR  <= acc.rd ? {shreg[CMD_ADDR_W-2:0], din} : acc.addr;
      ACC_WDATA <= {acc.wdata[DATA_W-2:0], din};
    end
  end
endmodule : sdp_top
